// [verilog/scg_pkg.sv]
// Behaviour
// - Each module clock domain except the program store stops on its own, as the chosen sleep mode dictates.
// - Core domain gated off freezes register file, status and stack memory.
// - Peripheral domain feeds peripherals; some interrupts still wake it asynchronously.
// - Serial address match wakes the device even with peripheral clock stopped.
// - Program store clock runs and stops together with the core clock.
// - Async timer domain runs from the 32 kHz crystal in idle, noise reduction, power-save and extended standby sleep.
// - Converter domain keeps running in noise reduction mode while core and peripheral clocks stop.
// - Source fuses decode: crystal, low-frequency crystal, RC, internal RC, external.
// - Fuse bits are inverted: stored one is unprogrammed, zero programmed.
// - Only the selected source drives the clock generator and every domain except the async timer.
// - Wake from power-down or save counts source cycles before execution.
// - Start from reset adds no delay, 4096 or 65536 supervisory oscillator cycles.
// - Fuses default to source 0001 and start-up 10 before capture.
// - Crystal: lowest source bit and start-up bits pick wake and reset delays.
package scg_pkg;

    // Factory fuse contents, stored polarity
    localparam logic [3:0] FUSE_SRC_DEFAULT = 4'h1;
    localparam logic [1:0] FUSE_SUT_DEFAULT = 2'h2;
    localparam logic       FUSE_AMP_DEFAULT = 1'h1;

    // Register map of the plain software port
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_FUSE = 2'h2;
    localparam logic [1:0] ADDR_PROG = 2'h3;
    localparam int         CTRL_GO_BIT = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h00;

    // Sleep mode codes written into the control register
    localparam logic [2:0] MODE_IDLE  = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY  = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;

    // Start-up counts in cycles of the counted oscillator
    localparam int WAKE_258   = 258;
    localparam int WAKE_1K    = 1024;
    localparam int WAKE_16K   = 16384;
    localparam int WAKE_32K   = 32768;
    localparam int WAKE_OTHER = 6;
    localparam int RST_SHORT  = 4096;
    localparam int RST_LONG   = 65536;
    localparam int CNT_W      = 17;

    typedef enum logic [2:0] {
        SRC_EXT_CLK, SRC_INT_RC, SRC_EXT_RC, SRC_LF_XTAL, SRC_XTAL
    } scg_src_t;

    // Raw oscillator levels, one per candidate source
    typedef struct packed {
        logic xtal;
        logic lf_xtal;
        logic ext_rc;
        logic int_rc;
        logic ext_clk;
    } scg_srcs_t;

    // Per-domain run requests
    typedef struct packed {
        logic core;
        logic io;
        logic flash;
        logic asy;
        logic adc;
    } scg_dom_t;

endpackage

// [verilog/scg_gate.sv]
`timescale 1ns/10ps
module scg_gate
    import scg_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic en_req,
    input  wire logic src_level,
    output logic      gclk
);

    logic src_reg, src_next;
    logic en_reg,  en_next;
    logic gclk_next;

    // Enable may only change while the source is low, so a pulse is never cut
    always_comb begin
        src_next  = src_level;
        en_next   = src_reg ? en_reg : en_req;
        gclk_next = en_reg & src_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= 1'h0;
            en_reg  <= 1'h0;
            gclk    <= 1'h0;
        end else if (ce) begin
            src_reg <= src_next;
            en_reg  <= en_next;
            gclk    <= gclk_next;
        end
    end

    a_gate_no_cut: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($past(ce) && $fell(gclk)) |-> !$past(src_reg))
        else $error("gated clock fell while source still high");

    a_gate_whole_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($past(ce) && $past(ce, 2) && $rose(gclk)) |-> !$past(src_reg, 2))
        else $error("gated clock started mid pulse");

endmodule

// [verilog/scg_top.sv]
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module scg_top
    import scg_pkg::*;
#(
    parameter int W258   = WAKE_258,
    parameter int W1K    = WAKE_1K,
    parameter int W16K   = WAKE_16K,
    parameter int W32K   = WAKE_32K,
    parameter int WOTHER = WAKE_OTHER,
    parameter int RSHORT = RST_SHORT,
    parameter int RLONG  = RST_LONG
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic [3:0] source_select_fuses,
    input  wire logic [1:0] startup_select_fuses,
    input  wire logic       amplifier_option_fuse,
    input  wire scg_srcs_t  osc_levels,
    input  wire logic       supervisory_oscillator,
    input  wire logic       async_xtal_level,
    input  wire logic       async_irq_req,
    input  wire logic       sync_irq_req,
    input  wire logic       twi_addr_match,
    output logic            core_domain_clock,
    output logic            peripheral_domain_clock,
    output logic            program_store_clock,
    output logic            async_timer_clock,
    output logic            converter_domain_clock,
    output logic            exec_enable,
    output logic            core_state_hold
);

    typedef enum logic [2:0] {ST_LOAD, ST_START, ST_RST_DLY, ST_RUN, ST_SLEEP, ST_WAKE} scg_st_t;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_reg;
    logic       rst_n;

    // Assert immediately, release two edges later to avoid a metastable release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Stored fuse values map straight onto the source classes
    function automatic scg_src_t src_class(input logic [3:0] f);
        if (f >= 4'hA)      src_class = SRC_XTAL;
        else if (f == 4'h9) src_class = SRC_LF_XTAL;
        else if (f >= 4'h5) src_class = SRC_EXT_RC;
        else if (f >= 4'h1) src_class = SRC_INT_RC;
        else                src_class = SRC_EXT_CLK;
    endfunction

    function automatic logic [CNT_W-1:0] wake_lim(input scg_src_t c, input logic f0,
                                                  input logic [1:0] s);
        wake_lim = CNT_W'(WOTHER);
        if (c == SRC_XTAL) begin
            if (!f0) wake_lim = (s < 2'h2) ? CNT_W'(W258) : CNT_W'(W1K);
            else     wake_lim = (s == 2'h0) ? CNT_W'(W1K) : CNT_W'(W16K);
        end else if (c == SRC_LF_XTAL) begin
            wake_lim = (s == 2'h2) ? CNT_W'(W32K) : CNT_W'(W1K);
        end
    endfunction

    function automatic logic [CNT_W-1:0] rst_lim(input scg_src_t c, input logic f0,
                                                 input logic [1:0] s);
        logic [1:0] k;
        k = 2'h2;
        if (c == SRC_XTAL) begin
            // Code 0 is no delay, 1 short, 2 long
            unique case ({f0, s})
                3'h0, 3'h3, 3'h6: k = 2'h1;
                3'h1, 3'h4, 3'h7: k = 2'h2;
                3'h2, 3'h5:       k = 2'h0;
            endcase
        end else if (c == SRC_LF_XTAL) begin
            k = (s == 2'h0) ? 2'h1 : 2'h2;
        end else begin
            k = (s == 2'h0) ? 2'h0 : ((s == 2'h1) ? 2'h1 : 2'h2);
        end
        rst_lim = (k == 2'h0) ? '0 : ((k == 2'h1) ? CNT_W'(RSHORT) : CNT_W'(RLONG));
    endfunction

    // Which domains stay alive in each sleep mode
    function automatic scg_dom_t sleep_plan(input logic [2:0] m);
        sleep_plan = '0;
        unique case (m)
            MODE_IDLE:  sleep_plan = '{core: 1'h0, io: 1'h1, flash: 1'h0, asy: 1'h1, adc: 1'h1};
            MODE_ADCNR: sleep_plan = '{core: 1'h0, io: 1'h0, flash: 1'h0, asy: 1'h1, adc: 1'h1};
            MODE_PSAVE, MODE_XSTBY: sleep_plan.asy = 1'h1;
            default:    sleep_plan = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Control state

    scg_st_t          state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg,   cnt_next;
    logic [3:0]       fsrc_reg,  fsrc_next;
    logic [1:0]       fsut_reg,  fsut_next;
    logic             famp_reg,  famp_next;
    logic [2:0]       mode_reg,  mode_next;
    logic             srcl_reg,  srcl_next;
    logic             srcp_reg,  srcp_next;
    logic             wdt_reg,   wdt_next;
    logic             wdtp_reg,  wdtp_next;
    scg_dom_t         dom_reg,   dom_next;
    logic             exec_next, hold_next;
    logic [7:0]       rdata_next;
    scg_src_t         cls;
    logic             src_edge, wdt_edge, wake, go;
    logic [CNT_W-1:0] wlim, rlim;

    always_comb begin
        cls      = src_class(fsrc_reg);
        wlim     = wake_lim(cls, fsrc_reg[0], fsut_reg);
        rlim     = rst_lim(cls, fsrc_reg[0], fsut_reg);
        src_edge = srcl_reg & ~srcp_reg;
        wdt_edge = wdt_reg & ~wdtp_reg;
        go       = wr_stb && addr == ADDR_CTRL && wdata[CTRL_GO_BIT];
        // Asynchronous interrupt and serial address paths need no peripheral clock
        wake     = async_irq_req | twi_addr_match | (sync_irq_req & dom_reg.io);
    end

    // Sequencer, fuse capture, source selection and domain requests
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        fsrc_next  = fsrc_reg;
        fsut_next  = fsut_reg;
        famp_next  = famp_reg;
        mode_next  = mode_reg;
        // Only the chosen oscillator reaches the generator
        unique case (cls)
            SRC_XTAL:    srcl_next = osc_levels.xtal;
            SRC_LF_XTAL: srcl_next = osc_levels.lf_xtal;
            SRC_EXT_RC:  srcl_next = osc_levels.ext_rc;
            SRC_INT_RC:  srcl_next = osc_levels.int_rc;
            default:     srcl_next = osc_levels.ext_clk;
        endcase
        srcp_next = srcl_reg;
        wdt_next  = supervisory_oscillator;
        wdtp_next = wdt_reg;
        if (wr_stb && addr == ADDR_CTRL) begin
            mode_next = wdata[3:1];
        end
        unique case (state_reg)
            ST_LOAD: begin
                fsrc_next  = source_select_fuses;
                fsut_next  = startup_select_fuses;
                famp_next  = amplifier_option_fuse;
                cnt_next   = '0;
                state_next = ST_START;
            end
            ST_START: begin
                if (src_edge) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (cnt_reg == wlim - CNT_W'(1)) begin
                        cnt_next   = '0;
                        state_next = (rlim == '0) ? ST_RUN : ST_RST_DLY;
                    end
                end
            end
            ST_RST_DLY: begin
                // Counted on the supervisory oscillator, independent of the source
                if (wdt_edge) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (cnt_reg == rlim - CNT_W'(1)) begin
                        cnt_next   = '0;
                        state_next = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (go) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    cnt_next   = '0;
                    state_next = (mode_reg == MODE_PDOWN || mode_reg == MODE_PSAVE) ?
                                 ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (src_edge) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (cnt_reg == wlim - CNT_W'(1)) begin
                        cnt_next   = '0;
                        state_next = ST_RUN;
                    end
                end
            end
            default: state_next = ST_LOAD;
        endcase
        // Domain requests follow the next state; flash always tracks core
        unique case (state_next)
            ST_RUN:            dom_next = '1;
            ST_SLEEP, ST_WAKE: dom_next = sleep_plan(mode_next);
            default:           dom_next = '{core: 1'h0, io: 1'h0, flash: 1'h0,
                                            asy: 1'h1, adc: 1'h0};
        endcase
        dom_next.flash = dom_next.core;
        exec_next = state_next == ST_RUN;
        hold_next = !dom_next.core;
    end

    // Read data stands for exactly one cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                ADDR_CTRL: rdata_next = {4'h0, mode_reg, 1'h0};
                ADDR_STAT: rdata_next = {exec_enable, 2'h0, dom_reg};
                ADDR_FUSE: rdata_next = {1'h0, famp_reg, fsut_reg, fsrc_reg};
                ADDR_PROG: rdata_next = {1'h0, ~famp_reg, ~fsut_reg, ~fsrc_reg};
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= ST_LOAD;
            cnt_reg         <= '0;
            fsrc_reg        <= FUSE_SRC_DEFAULT;
            fsut_reg        <= FUSE_SUT_DEFAULT;
            famp_reg        <= FUSE_AMP_DEFAULT;
            mode_reg        <= CTRL_RESET[3:1];
            srcl_reg        <= 1'h0;
            srcp_reg        <= 1'h0;
            wdt_reg         <= 1'h0;
            wdtp_reg        <= 1'h0;
            dom_reg         <= '0;
            exec_enable     <= 1'h0;
            core_state_hold <= 1'h1;
            rdata           <= 8'h00;
        end else if (ce) begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            fsrc_reg        <= fsrc_next;
            fsut_reg        <= fsut_next;
            famp_reg        <= famp_next;
            mode_reg        <= mode_next;
            srcl_reg        <= srcl_next;
            srcp_reg        <= srcp_next;
            wdt_reg         <= wdt_next;
            wdtp_reg        <= wdtp_next;
            dom_reg         <= dom_next;
            exec_enable     <= exec_next;
            core_state_hold <= hold_next;
            rdata           <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Glitch-free domain gates; the timer gate runs from the watch crystal directly

    logic [4:0] gate_en;
    logic [4:0] gate_src;
    logic [4:0] gate_out;

    assign gate_en  = {dom_reg.core, dom_reg.io, dom_reg.flash, dom_reg.asy, dom_reg.adc};
    assign gate_src = {srcl_reg, srcl_reg, srcl_reg, async_xtal_level, srcl_reg};

    for (genvar g = 0; g < 5; g++) begin : g_gate
        scg_gate u_gate (
            .clk_sys   (clk_sys),
            .rst_n     (rst_n),
            .ce        (ce),
            .en_req    (gate_en[g]),
            .src_level (gate_src[g]),
            .gclk      (gate_out[g])
        );
    end

    assign core_domain_clock       = gate_out[4];
    assign peripheral_domain_clock = gate_out[3];
    assign program_store_clock     = gate_out[2];
    assign async_timer_clock       = gate_out[1];
    assign converter_domain_clock  = gate_out[0];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_flash_with_core: assert property (@(posedge clk_sys) disable iff (!rst_n)
        program_store_clock == core_domain_clock)
        else $error("program store clock differs from core clock");

    a_core_stopped_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_SLEEP) |-> (!exec_enable && core_state_hold && !dom_reg.core))
        else $error("core domain live during sleep");

    a_wake_count_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ce && state_reg == ST_WAKE && state_next == ST_RUN)
            |-> (src_edge && cnt_reg == wlim - CNT_W'(1)) ##1 exec_enable)
        else $error("execution resumed before wake count");

    a_reset_delay_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RST_DLY ##1 state_reg == ST_RUN)
            |-> ($past(cnt_reg) == rlim - CNT_W'(1) && (rlim == CNT_W'(RSHORT)
                 || rlim == CNT_W'(RLONG))))
        else $error("reset delay not 4096 or 65536 supervisory cycles");

    a_async_wakes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ce && state_reg == ST_SLEEP && (async_irq_req || twi_addr_match))
            |=> state_reg != ST_SLEEP)
        else $error("asynchronous wake source ignored");

    a_noise_mode_domains: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_SLEEP && mode_reg == MODE_ADCNR)
            |-> (dom_reg.adc && dom_reg.asy && !dom_reg.io && !dom_reg.core))
        else $error("noise reduction mode domains wrong");

    a_src_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fsrc_reg == 4'h9 |-> cls == SRC_LF_XTAL) and (fsrc_reg == 4'h0 |-> cls == SRC_EXT_CLK)
            and (fsrc_reg == 4'hA |-> cls == SRC_XTAL))
        else $error("source fuse decode wrong");

    a_crystal_long: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cls == SRC_XTAL && fsrc_reg[0] && fsut_reg == 2'h3)
            |-> (wlim == CNT_W'(W16K) && rlim == CNT_W'(RLONG)))
        else $error("crystal start-up selection wrong");

endmodule

// [tb/scg_osc_model.sv]
`timescale 1ns/10ps
module scg_osc_model
    import scg_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic slow,
    output scg_srcs_t osc_levels,
    output logic      supervisory_oscillator,
    output logic      async_xtal_level
);
    ////////////////////////////////////////////////////////////////////////////////
    // Half periods: ext_clk, int_rc, ext_rc, lf_xtal, xtal, timer crystal, supervisory
    localparam int HP [7] = '{5, 4, 3, 6, 2, 7, 5};
    int         cnt_reg [7] = '{default: 0};
    logic [6:0] lvl_reg     = 7'h00;

    // Oscillators run free; slow stretches only the supervisory one,
    // since its rate drifts with supply and start-up must not depend on it
    always @(posedge clk_sys) begin
        for (int i = 0; i < 7; i++) begin
            if (cnt_reg[i] >= HP[i] - 1 + ((i == 6 && slow) ? 4 : 0)) begin
                cnt_reg[i] <= 0;
                lvl_reg[i] <= ~lvl_reg[i];
            end else begin
                cnt_reg[i] <= cnt_reg[i] + 1;
            end
        end
    end

    // Distinct rates so a wrongly chosen source shows up in the counts
    assign osc_levels             = scg_srcs_t'(lvl_reg[4:0]);
    assign async_xtal_level       = lvl_reg[5];
    assign supervisory_oscillator = lvl_reg[6];
endmodule

// [tb/scg_top_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module scg_top_tb
    import scg_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int W258 = 3, W1K = 4, W16K = 12, W32K = 14, WOTH = 6, RS = 8, RL = 16;
    localparam int         HP [5]    = '{5, 4, 3, 6, 2};
    localparam logic [2:0] MD [6]    = '{MODE_IDLE, MODE_ADCNR, MODE_PDOWN, MODE_PSAVE,
                                         MODE_STBY, MODE_XSTBY};
    localparam logic [4:0] RUNV [6]  = '{5'h0B, 5'h03, 5'h00, 5'h02, 5'h00, 5'h02};
    localparam logic [3:0] CODES [5] = '{4'hF, 4'h9, 4'h8, 4'h4, 4'h0};

    logic       clk_sys = 1'b0, arst_n = 1'b0, ce = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [1:0] addr    = 2'h0;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] rdata;
    logic [3:0] src_f   = FUSE_SRC_DEFAULT;
    logic [1:0] sut_f   = FUSE_SUT_DEFAULT;
    logic       amp_f   = FUSE_AMP_DEFAULT;
    logic       slow = 1'b0, async_irq = 1'b0, sync_irq = 1'b0, addr_hit = 1'b0;
    scg_srcs_t  osc;
    logic [4:0] ov, pl = 5'h00;
    logic       sup, axtal, cclk, pclk, fclk, aclk, dclk, exec_en, hold, ps = 1'b0;
    int         fails = 0, check_count = 0, cyc = 0, src_cnt = 0, sup_cnt = 0, hw = 0, sel = 1;

    assign ov = osc;
    always #25 clk_sys = ~clk_sys;

    scg_osc_model i_scg_osc_model (.clk_sys(clk_sys), .slow(slow), .osc_levels(osc),
        .supervisory_oscillator(sup), .async_xtal_level(axtal));
    scg_top #(.W258(W258), .W1K(W1K), .W16K(W16K), .W32K(W32K), .WOTHER(WOTH), .RSHORT(RS),
        .RLONG(RL)) i_scg_top (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .source_select_fuses(src_f), .startup_select_fuses(sut_f),
        .amplifier_option_fuse(amp_f), .osc_levels(osc), .supervisory_oscillator(sup),
        .async_xtal_level(axtal), .async_irq_req(async_irq), .sync_irq_req(sync_irq),
        .twi_addr_match(addr_hit), .core_domain_clock(cclk), .peripheral_domain_clock(pclk),
        .program_store_clock(fclk), .async_timer_clock(aclk), .converter_domain_clock(dclk),
        .exec_enable(exec_en), .core_state_hold(hold));

    ////////////////////////////////////////////////////////////////////////////////
    // Source index in the oscillator struct for a stored fuse code
    function automatic int sel_idx(input logic [3:0] s);
        if (s >= 4'hA) return 4;
        if (s == 4'h9) return 3;
        if (s >= 4'h5) return 2;
        return (s != 4'h0) ? 1 : 0;
    endfunction
    // Wake count in selected source cycles
    function automatic int exp_wake(input logic [3:0] s, input logic [1:0] u);
        case (sel_idx(s))
            4: return s[0] ? ((u == 2'h0) ? W1K : W16K) : (u[1] ? W1K : W258);
            3: return (u == 2'h2) ? W32K : W1K;
            default: return WOTH;
        endcase
    endfunction
    // Extra reset delay in supervisory cycles
    function automatic int exp_rst(input logic [3:0] s, input logic [1:0] u);
        int k;
        k = {s[0], u};
        case (sel_idx(s))
            4: return (k % 3 == 0) ? RS : (k % 3 == 1) ? RL : 0;
            3: return (u == 2'h0) ? RS : RL;
            default: return (u == 2'h0) ? 0 : (u == 2'h1) ? RS : RL;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [1:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask
    task automatic wait_exec();
        int n;
        n = 0;
        while (exec_en !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic a);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        src_f <= s;
        sut_f <= u;
        amp_f <= a;
        @(posedge clk_sys);
        #1;
        `CHK("state hold", 1'b1, hold)
        `CHK("exec in reset", 1'b0, exec_en)
        sel = sel_idx(s);
        src_cnt = 0;
        sup_cnt = 0;
        @(posedge clk_sys);
        arst_n <= 1'b1;
    endtask

    // Edge counters, core pulse widths and the run time ceiling
    always @(posedge clk_sys) begin
        cyc++;
        if (ov[sel] && !pl[sel]) src_cnt++;
        if (sup && !ps) sup_cnt++;
        pl = ov;
        ps = sup;
        if (cclk === 1'b1) begin
            hw++;
        end else begin
            if (hw != 0 && arst_n) `CHK("core pulse", HP[sel], hw)
            hw = 0;
        end
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Start under each source family, sleep in each mode, wake by each path
    initial begin
        logic [3:0] s;
        logic [1:0] u;
        logic       a;
        logic [4:0] act, prv, cur;
        int         m;
        void'($urandom(32'h95CADC4C));
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? FUSE_SRC_DEFAULT : (i < 6) ? CODES[i - 1] : 4'($urandom);
            u = (i == 0) ? FUSE_SUT_DEFAULT : 2'($urandom);
            if (s == 4'h9 && u == 2'h3) u = 2'h0; // Reserved pairing avoided
            a = (i == 0) ? FUSE_AMP_DEFAULT : (sel_idx(s) == 4) ? 1'b0 : 1'($urandom);
            m = i % 6;
            slow <= 1'($urandom);
            do_reset(s, u, a);
            wait_exec();
            `CHK("exec after start", 1'b1, exec_en)
            `CHK("core live", 1'b0, hold)
            `CHK("start count", 1'b1, src_cnt >= exp_wake(s, u))
            `CHK("reset delay", 1'b1, sup_cnt >= exp_rst(s, u))
            chk_rd(ADDR_FUSE, {1'b0, a, u, s}, "fuse");
            chk_rd(ADDR_PROG, {1'b0, ~a, ~u, ~s}, "programmed");
            chk_rd(ADDR_STAT, 8'h9F, "run status");
            wr(ADDR_CTRL, {4'h0, MD[m], 1'b1});
            repeat (16) @(posedge clk_sys);
            chk_rd(ADDR_CTRL, {4'h0, MD[m], 1'b0}, "control");
            chk_rd(ADDR_STAT, {3'h0, RUNV[m]}, "sleep status");
            act = 5'h00;
            prv = {cclk, pclk, fclk, aclk, dclk};
            repeat (40) begin
                @(posedge clk_sys);
                #1;
                cur = {cclk, pclk, fclk, aclk, dclk};
                act |= prv ^ cur;
                prv = cur;
            end
            `CHK("domains running", RUNV[m], act)
            `CHK("core frozen", 1'b1, hold)
            // Enable low must freeze every gated level, running domains included
            @(posedge clk_sys);
            ce <= 1'b0;
            #1;
            prv = {cclk, pclk, fclk, aclk, dclk};
            repeat (8) @(posedge clk_sys);
            ce <= 1'b1;
            #1;
            `CHK("frozen domains", prv, {cclk, pclk, fclk, aclk, dclk})
            if (m != 0) begin
                @(posedge clk_sys);
                sync_irq <= 1'b1;
                repeat (6) @(posedge clk_sys);
                sync_irq <= 1'b0;
                #1;
                `CHK("refused wake", 1'b0, exec_en)
            end
            @(posedge clk_sys);
            #1;
            src_cnt = 0;
            @(posedge clk_sys);
            if (m == 0) sync_irq <= 1'b1;
            else if (i % 2 == 1) addr_hit <= 1'b1;
            else async_irq <= 1'b1;
            wait_exec();
            `CHK("woken", 1'b1, exec_en)
            if (MD[m] == MODE_PDOWN || MD[m] == MODE_PSAVE)
                `CHK("wake count", 1'b1, src_cnt >= exp_wake(s, u))
            @(posedge clk_sys);
            sync_irq <= 1'b0;
            addr_hit <= 1'b0;
            async_irq <= 1'b0;
            $display("test %0d done", i);
        end
        conclude();
    end
endmodule
